// >>> hw/acr_pkg.sv
package acr_pkg;

   // Register indices on the byte-wide register port
   localparam logic [2:0] ADDR_CTL0   = 3'h0;
   localparam logic [2:0] ADDR_CTL1   = 3'h1;
   localparam logic [2:0] ADDR_CTL2   = 3'h2;
   localparam logic [2:0] ADDR_RES_HI = 3'h3;
   localparam logic [2:0] ADDR_RES_LO = 3'h4;

   // Field positions
   localparam int EN_BIT   = 0;
   localparam int GO_BIT   = 1;
   localparam int PCH_LSB  = 2;
   localparam int NCH_LSB  = 0;
   localparam int NREF_BIT = 3;
   localparam int PREF_LSB = 4;
   localparam int TRIG_LSB = 6;
   localparam int CLK_LSB  = 0;
   localparam int ACQ_LSB  = 3;
   localparam int FMT_BIT  = 7;

   // Reset values
   localparam logic [7:0] CTL0_RESET = 8'h00;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [7:0] CTL2_RESET = 8'h00;

   // Conversion clock codes that pick the internal RC clock
   localparam logic [1:0] CLK_RC_LOW = 2'h3;

   // One instruction cycle of four oscillator periods at 125 MHz
   localparam int CLK_NS         = 8;
   localparam int TCY_NS         = 32;
   localparam int RC_WAIT_CYCLES = (TCY_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {
      st_idle, st_rc_wait, st_acquire, st_convert
   } acr_state_t;

   // Settings and timing handed to the converter core
   typedef struct packed {
      logic       enable;
      logic [4:0] positive_channel_select;
      logic [2:0] negative_channel_select;
      logic [1:0] positive_reference_select;
      logic       negative_reference_select;
      logic [1:0] special_trigger_select;
      logic       acquiring;
      logic       converting;
      logic       tad_tick;
   } acr_core_ctl_t;

   // Answer from the converter core
   typedef struct packed {
      logic        done;
      logic [11:0] magnitude;
      logic        negative;
   } acr_core_res_t;

   // Acquisition length in converter clock periods
   function automatic logic [4:0] acr_acq_periods(input logic [2:0] code);
      case (code)
         3'h0: acr_acq_periods = 5'h00;
         3'h1: acr_acq_periods = 5'h02;
         3'h2: acr_acq_periods = 5'h04;
         3'h3: acr_acq_periods = 5'h06;
         3'h4: acr_acq_periods = 5'h08;
         3'h5: acr_acq_periods = 5'h0c;
         3'h6: acr_acq_periods = 5'h10;
         default: acr_acq_periods = 5'h14;
      endcase
   endfunction

   // Last count of the system clock divider: ratio minus one
   function automatic logic [5:0] acr_div_last(input logic [2:0] code);
      case (code)
         3'h0: acr_div_last = 6'h01;
         3'h1: acr_div_last = 6'h07;
         3'h2: acr_div_last = 6'h1f;
         3'h4: acr_div_last = 6'h03;
         3'h5: acr_div_last = 6'h0f;
         3'h6: acr_div_last = 6'h3f;
         default: acr_div_last = 6'h00;
      endcase
   endfunction

endpackage

// >>> hw/acr_top.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
// Behaviour
// - ctl0 bits 6-2 pick positive channel; 0-23 are external inputs.
// - codes 24-27 reserved; 28 charge unit, 29 temp, 30 core, 31 bandgap.
// - unimplemented channels give whatever the core returns.
// - writing one to ctl0 bit 1 starts; it reads one while busy.
// - hardware clears the busy bit when the conversion ends.
// - ctl0 bit 0 powers the converter; ctl0 bit 7 reads zero.
// - ctl1 bits 7-6 choose the special trigger source.
// - ctl1 bits 5-4 choose the positive reference.
// - ctl1 bit 3 chooses the negative reference.
// - ctl1 bits 2-0 pick negative channel; zero is analog ground.
// - ctl2 bit 7 picks right justified when one; bit 6 reads zero.
// - ctl2 bits 5-3 set acquisition of 0,2,4,6,8,12,16,20 periods.
// - ctl2 bits 2-0 pick clock divide 2,8,32,4,16,64 or RC clock.
// - with the RC clock, wait one instruction cycle before clocking.
// - each finished conversion loads result and sign into the pair.
// - result bytes are plain read/write storage while disabled.
// - left format: high holds bits 11-4, low holds 3-0 then sign.
// - right format: high byte holds four sign bits then bits 11-8.
// - every sign bit is one for negative results, zero otherwise.
// - right format: low byte holds result bits 7-0.
// - completion loads the pair, clears busy, pulses the done flag.
// - reset clears control and aborts; result pair is left unset.
// - core converts positive minus negative channel difference.
module acr_top (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // Register port
   input  wire logic [2:0]             addr,
   input  wire logic [7:0]             wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic [7:0]                  rdata,
   // Converter core
   input  wire acr_pkg::acr_core_res_t core_res,
   output acr_pkg::acr_core_ctl_t      core_ctl,
   // Trigger sources, internal RC clock and done flag
   input  wire logic [3:0]             special_trigger,
   input  wire logic                   rc_clock_tick,
   output logic                        conversion_done_flag
);

   logic                rst_meta;
   logic                rst_sync;
   logic [7:0]          ctl0;
   logic [7:0]          ctl1;
   logic [7:0]          ctl2;
   logic [7:0]          result_high_byte;
   logic [7:0]          result_low_byte;
   acr_pkg::acr_state_t state;
   logic [4:0]          acq_left;
   logic [2:0]          rc_cnt;
   logic [5:0]          div_cnt;
   logic                tad_tick;
   logic                wr_ctl0;
   logic                next_enable;
   logic                start_req;
   logic                use_rc;
   logic                busy;
   logic                finish;
   logic [15:0]         next_pair;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   assign wr_ctl0     = wr && (addr == acr_pkg::ADDR_CTL0);
   assign next_enable = wr_ctl0 ? wdata[acr_pkg::EN_BIT]
                                : ctl0[acr_pkg::EN_BIT];
   assign use_rc      = (ctl2[acr_pkg::CLK_LSB +: 2] == acr_pkg::CLK_RC_LOW);
   assign busy        = (state != acr_pkg::st_idle);
   // Busy wins over a go write and the trigger, so a start is one-shot
   assign start_req   = next_enable && !busy &&
                        ((wr_ctl0 && wdata[acr_pkg::GO_BIT]) ||
                         special_trigger[ctl1[acr_pkg::TRIG_LSB +: 2]]);
   assign finish      = (state == acr_pkg::st_convert) && core_res.done &&
                        next_enable;

   // Sign copies fill the four spare bits of the pair
   always_comb begin
      if (ctl2[acr_pkg::FMT_BIT])
         next_pair = {{4{core_res.negative}}, core_res.magnitude};
      else
         next_pair = {core_res.magnitude, {4{core_res.negative}}};
   end

   // Control registers; busy bit lives in the sequencer state
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         ctl0 <= acr_pkg::CTL0_RESET;
         ctl1 <= acr_pkg::CTL1_RESET;
         ctl2 <= acr_pkg::CTL2_RESET;
      end else if (wr) begin
         case (addr)
            acr_pkg::ADDR_CTL0: ctl0 <= {1'b0, wdata[6:2], 1'b0, wdata[0]};
            acr_pkg::ADDR_CTL1: ctl1 <= wdata;
            acr_pkg::ADDR_CTL2: ctl2 <= {wdata[7], 1'b0, wdata[5:0]};
            default: ;
         endcase
      end
   end

   // No reset: the pair keeps whatever it holds across reset
   always_ff @(posedge clk) begin
      if (finish) begin
         result_high_byte <= next_pair[15:8];
         result_low_byte  <= next_pair[7:0];
      end else if (wr && addr == acr_pkg::ADDR_RES_HI) begin
         result_high_byte <= wdata;
      end else if (wr && addr == acr_pkg::ADDR_RES_LO) begin
         result_low_byte <= wdata;
      end
   end

   // Converter clock: divided system clock or the RC tick
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         div_cnt  <= 6'h00;
         tad_tick <= 1'b0;
      end else if (!busy || state == acr_pkg::st_rc_wait) begin
         div_cnt  <= 6'h00;
         tad_tick <= 1'b0;
      end else if (use_rc) begin
         div_cnt  <= 6'h00;
         tad_tick <= rc_clock_tick;
      end else if (div_cnt >=
                   acr_pkg::acr_div_last(ctl2[acr_pkg::CLK_LSB +: 3])) begin
         div_cnt  <= 6'h00;
         tad_tick <= 1'b1;
      end else begin
         div_cnt  <= div_cnt + 6'h01;
         tad_tick <= 1'b0;
      end
   end

   // Sequencer
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         state    <= acr_pkg::st_idle;
         acq_left <= 5'h00;
         rc_cnt   <= 3'h0;
      end else if (!next_enable) begin
         state    <= acr_pkg::st_idle;
         acq_left <= 5'h00;
         rc_cnt   <= 3'h0;
      end else begin
         unique case (state)
            acr_pkg::st_idle: begin
               if (start_req) begin
                  state    <= use_rc ? acr_pkg::st_rc_wait
                                     : acr_pkg::st_acquire;
                  acq_left <= acr_pkg::acr_acq_periods(
                                 ctl2[acr_pkg::ACQ_LSB +: 3]);
                  rc_cnt   <= 3'h0;
               end
            end
            acr_pkg::st_rc_wait: begin
               rc_cnt <= rc_cnt + 3'h1;
               if (rc_cnt == 3'(acr_pkg::RC_WAIT_CYCLES - 1))
                  state <= acr_pkg::st_acquire;
            end
            acr_pkg::st_acquire: begin
               if (acq_left == 5'h00)
                  state <= acr_pkg::st_convert;
               else if (tad_tick)
                  acq_left <= acq_left - 5'h01;
            end
            acr_pkg::st_convert: begin
               if (core_res.done)
                  state <= acr_pkg::st_idle;
            end
         endcase
      end
   end

   // Settings to the core, registered
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         core_ctl <= '0;
      end else begin
         core_ctl.enable                    <= ctl0[acr_pkg::EN_BIT];
         core_ctl.positive_channel_select   <=
            ctl0[acr_pkg::PCH_LSB +: 5];
         core_ctl.negative_channel_select   <=
            ctl1[acr_pkg::NCH_LSB +: 3];
         core_ctl.positive_reference_select <=
            ctl1[acr_pkg::PREF_LSB +: 2];
         core_ctl.negative_reference_select <= ctl1[acr_pkg::NREF_BIT];
         core_ctl.special_trigger_select    <= ctl1[acr_pkg::TRIG_LSB +: 2];
         core_ctl.acquiring  <= (state == acr_pkg::st_acquire);
         core_ctl.converting <= (state == acr_pkg::st_convert);
         core_ctl.tad_tick   <= tad_tick;
      end
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync)
         conversion_done_flag <= 1'b0;
      else
         conversion_done_flag <= finish;
   end

   // Read data stand in the cycle after the strobe only
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            acr_pkg::ADDR_CTL0:
               rdata <= {ctl0[7:2], busy, ctl0[0]};
            acr_pkg::ADDR_CTL1:   rdata <= ctl1;
            acr_pkg::ADDR_CTL2:   rdata <= ctl2;
            acr_pkg::ADDR_RES_HI: rdata <= result_high_byte;
            acr_pkg::ADDR_RES_LO: rdata <= result_low_byte;
            default:              rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // Checks
   a_go_reads_busy: assert property (@(posedge clk) disable iff (!rst_sync)
      rd && addr == acr_pkg::ADDR_CTL0 |=> rdata[acr_pkg::GO_BIT] == $past(busy))
      else $error("busy bit does not match sequencer");
   a_start_sets_busy: assert property (@(posedge clk) disable iff (!rst_sync)
      start_req |=> busy)
      else $error("start did not make the block busy");
   a_done_clears_go: assert property (@(posedge clk) disable iff (!rst_sync)
      finish |=> !busy ##0 conversion_done_flag)
      else $error("completion did not clear busy and flag done");
   a_ctl0_top_zero: assert property (@(posedge clk) disable iff (!rst_sync)
      rd && addr == acr_pkg::ADDR_CTL0 |=> !rdata[7])
      else $error("control 0 bit 7 not zero");
   a_ctl2_bit_zero: assert property (@(posedge clk) disable iff (!rst_sync)
      rd && addr == acr_pkg::ADDR_CTL2 |=> !rdata[6])
      else $error("control 2 bit 6 not zero");
   a_disable_aborts: assert property (@(posedge clk) disable iff (!rst_sync)
      busy && !next_enable |=> !busy ##1 !conversion_done_flag)
      else $error("disable did not abort");
   a_zero_acq_fast: assert property (@(posedge clk) disable iff (!rst_sync)
      state == acr_pkg::st_acquire && acq_left == 5'h00 && next_enable
      |=> state == acr_pkg::st_convert)
      else $error("acquisition did not end at zero");
   a_rc_wait_len: assert property (@(posedge clk)
      disable iff (!rst_sync || !ctl0[acr_pkg::EN_BIT])
      $rose(state == acr_pkg::st_rc_wait) |->
      (state == acr_pkg::st_rc_wait)[*4] ##1 state == acr_pkg::st_acquire)
      else $error("RC start delay is not one instruction cycle");
   a_right_sign: assert property (@(posedge clk) disable iff (!rst_sync)
      finish && ctl2[acr_pkg::FMT_BIT] |=>
      result_high_byte == {{4{$past(core_res.negative)}},
                           $past(core_res.magnitude[11:8])})
      else $error("right justified high byte wrong");
   a_left_sign: assert property (@(posedge clk) disable iff (!rst_sync)
      finish && !ctl2[acr_pkg::FMT_BIT] |=>
      result_low_byte == {$past(core_res.magnitude[3:0]),
                          {4{$past(core_res.negative)}}})
      else $error("left justified low byte wrong");

   // The go bit is never stored; busy comes from the sequencer alone
   a_go_write_clr: assert property (@(posedge clk)
      disable iff (!rst_sync)
      wr_ctl0 |=> !ctl0[acr_pkg::GO_BIT])
      else $error("go bit stored in control 0");

   a_left_high: assert property (@(posedge clk)
      disable iff (!rst_sync)
      finish && !ctl2[acr_pkg::FMT_BIT] |=>
      result_high_byte == $past(core_res.magnitude[11:4]))
      else $error("left justified high byte wrong");

   a_right_low: assert property (@(posedge clk)
      disable iff (!rst_sync)
      finish && ctl2[acr_pkg::FMT_BIT] |=>
      result_low_byte == $past(core_res.magnitude[7:0]))
      else $error("right justified low byte wrong");

   a_idle_when_off: assert property (@(posedge clk)
      disable iff (!rst_sync)
      !busy && !next_enable |=> !busy)
      else $error("sequencer left idle while disabled");

   a_acq_loaded: assert property (@(posedge clk)
      disable iff (!rst_sync)
      start_req |=>
      acq_left == acr_pkg::acr_acq_periods(
                     $past(ctl2[acr_pkg::ACQ_LSB +: 3])))
      else $error("acquisition count not loaded from setting");

   // Without a tick the acquisition count must hold
   a_acq_hold: assert property (@(posedge clk)
      disable iff (!rst_sync)
      state == acr_pkg::st_acquire && acq_left != 5'h00 &&
      !tad_tick && next_enable
      |=> state == acr_pkg::st_acquire && $stable(acq_left))
      else $error("acquisition count moved without a tick");

   // Every divide ratio is at least two, so ticks never touch
   a_tad_spacing: assert property (@(posedge clk)
      disable iff (!rst_sync)
      tad_tick && !use_rc && $stable(ctl2) |=> !tad_tick)
      else $error("divided converter clock ticks back to back");

   a_rc_wait_quiet: assert property (@(posedge clk)
      disable iff (!rst_sync)
      state == acr_pkg::st_rc_wait |=> !tad_tick)
      else $error("converter clock ran during the start delay");

   a_flag_from_finish: assert property (@(posedge clk)
      disable iff (!rst_sync)
      conversion_done_flag |-> $past(finish))
      else $error("done flag without a completion");

   a_core_enable: assert property (@(posedge clk)
      disable iff (!rst_sync)
      1'b1 |=> core_ctl.enable == $past(ctl0[acr_pkg::EN_BIT]))
      else $error("core enable does not follow control 0");

   a_core_pos_chan: assert property (@(posedge clk)
      disable iff (!rst_sync)
      1'b1 |=> core_ctl.positive_channel_select ==
               $past(ctl0[acr_pkg::PCH_LSB +: 5]))
      else $error("positive channel not passed to core");

   a_core_neg_chan: assert property (@(posedge clk)
      disable iff (!rst_sync)
      1'b1 |=> core_ctl.negative_channel_select ==
               $past(ctl1[acr_pkg::NCH_LSB +: 3]))
      else $error("negative channel not passed to core");

   a_core_pos_ref: assert property (@(posedge clk)
      disable iff (!rst_sync)
      1'b1 |=> core_ctl.positive_reference_select ==
               $past(ctl1[acr_pkg::PREF_LSB +: 2]))
      else $error("positive reference not passed to core");

   a_core_neg_ref: assert property (@(posedge clk)
      disable iff (!rst_sync)
      1'b1 |=> core_ctl.negative_reference_select ==
               $past(ctl1[acr_pkg::NREF_BIT]))
      else $error("negative reference not passed to core");

   a_core_trig_sel: assert property (@(posedge clk)
      disable iff (!rst_sync)
      1'b1 |=> core_ctl.special_trigger_select ==
               $past(ctl1[acr_pkg::TRIG_LSB +: 2]))
      else $error("trigger select not passed to core");

   // Coverage of the main scenarios

   c_conv_done: cover property (@(posedge clk) conversion_done_flag);
   c_rc_path: cover property (@(posedge clk)
      state == acr_pkg::st_rc_wait ##[1:300] conversion_done_flag);
   c_abort: cover property (@(posedge clk) busy && !next_enable);
   c_trigger: cover property (@(posedge clk)
      start_req && !wr_ctl0);

endmodule

// >>> verification/acr_core_model.sv
`timescale 1ns/1ns
module acr_core_model (
   // Clock
   input  wire logic                   clk,
   // Control from the block
   input  wire acr_pkg::acr_core_ctl_t ctl,
   // Answer set up by the bench
   input  wire logic [7:0]             conv_ticks,
   input  wire logic [11:0]            mag_in,
   input  wire logic                   neg_in,
   output acr_pkg::acr_core_res_t      res,
   // Observed timing
   output logic [7:0]                  acq_ticks,
   output logic [7:0]                  tick_gap
);
   logic [7:0] ticks;
   logic [7:0] gap;
   logic [7:0] acq_run;

   initial begin
      res = '0;
      ticks = 8'h00;
      gap = 8'h00;
      acq_run = 8'h00;
      acq_ticks = 8'h00;
      tick_gap = 8'h00;
   end

   always @(posedge clk) begin
      gap <= gap + 8'h01;
      res.done <= 1'b0;
      // Result lines are only valid beside done, so they toggle otherwise
      res.magnitude <= ~res.magnitude;
      res.negative <= ~res.negative;
      if (!ctl.acquiring && !ctl.converting) acq_run <= 8'h00;
      if (ctl.acquiring && ctl.tad_tick) acq_run <= acq_run + 8'h01;
      if (ctl.converting) acq_ticks <= acq_run;
      if (ctl.tad_tick) begin
         gap <= 8'h01;
         tick_gap <= gap;
      end
      if (!ctl.converting) ticks <= 8'h00;
      else if (ctl.tad_tick && ticks == conv_ticks - 8'h01) begin
         ticks <= 8'h00;
         res.done <= 1'b1;
         res.magnitude <= mag_in;
         res.negative <= neg_in;
      end else if (ctl.tad_tick) ticks <= ticks + 8'h01;
   end
endmodule

// >>> verification/acr_top_test.sv
`timescale 1ns/1ns
module acr_top_test;
   logic                   clk;
   logic                   rstn;
   logic [2:0]             addr;
   logic [7:0]             wdata;
   logic                   wr;
   logic                   rd;
   logic [7:0]             rdata;
   acr_pkg::acr_core_res_t core_res;
   acr_pkg::acr_core_ctl_t core_ctl;
   logic [3:0]             special_trigger;
   logic                   rc_clock_tick = 1'b0;
   logic                   conversion_done_flag;
   logic [7:0]             conv_ticks;
   logic [11:0]            mag_in;
   logic                   neg_in;
   logic [7:0]             acq_ticks;
   logic [7:0]             tick_gap;
   logic [2:0]             rc_cnt = 3'h0;
   logic [7:0]             rv;
   logic [7:0]             wv;
   logic [7:0]             got;
   logic                   seen;
   integer                 seed;
   integer                 bad_count;
   integer                 n_tests;
   localparam logic [7:0] ACQ_TAB [8] = '{8'h00, 8'h02, 8'h04, 8'h06,
                                          8'h08, 8'h0c, 8'h10, 8'h14};
   // RC codes expect the bench's tick spacing of five clocks
   localparam logic [7:0] GAP_TAB [8] = '{8'h02, 8'h08, 8'h20, 8'h05,
                                          8'h04, 8'h10, 8'h40, 8'h05};

   acr_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .core_res(core_res),
      .core_ctl(core_ctl), .special_trigger(special_trigger),
      .rc_clock_tick(rc_clock_tick),
      .conversion_done_flag(conversion_done_flag));
   acr_core_model core (.clk(clk), .ctl(core_ctl), .conv_ticks(conv_ticks),
      .mag_in(mag_in), .neg_in(neg_in), .res(core_res),
      .acq_ticks(acq_ticks), .tick_gap(tick_gap));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
      rc_clock_tick <= (rc_cnt == 3'h4);
   end

   function automatic logic [15:0] exp_pair(input logic fmt,
      input logic [11:0] m, input logic s);
      exp_pair = fmt ? {{4{s}}, m} : {m, {4{s}}};
   endfunction

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_tests = n_tests + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      n_tests = n_tests + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED at %0t: flag %b expected %b", $time, g, e);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic wait_done;
      for (int i = 0; i < 4000; i++) begin
         @(posedge clk);
         #1;
         if (conversion_done_flag === 1'b1) return;
      end
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: no completion", $time);
      stop_test();
   endtask

   task automatic pulse_trig(input logic [3:0] v);
      @(posedge clk);
      special_trigger <= v;
      @(posedge clk);
      special_trigger <= 4'h0;
   endtask

   initial begin
      seed = 32'h562fa3a9;
      bad_count = 0;
      n_tests = 0;
      rstn = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      special_trigger = 4'h0;
      conv_ticks = 8'h04;
      mag_in = 12'h000;
      neg_in = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a < 8; a++) begin
         if (a == 3 || a == 4) continue;
         rd_reg(3'(a), got);
         chk8(got, 8'h00);
      end
      // First pass uses all ones to hit the read-as-zero bits
      for (int i = 0; i < 5; i++) begin
         rv = (i == 0) ? 8'hff : 8'($random(seed));
         wr_reg(acr_pkg::ADDR_CTL1, rv);
         rd_reg(acr_pkg::ADDR_CTL1, got);
         chk8(got, rv);
         chk8({core_ctl.special_trigger_select,
               core_ctl.positive_reference_select,
               core_ctl.negative_reference_select,
               core_ctl.negative_channel_select}, rv);
         wr_reg(acr_pkg::ADDR_CTL2, rv);
         rd_reg(acr_pkg::ADDR_CTL2, got);
         chk8(got, rv & 8'hbf);
         wr_reg(acr_pkg::ADDR_CTL0, rv & 8'hfc);
         rd_reg(acr_pkg::ADDR_CTL0, got);
         chk8(got, rv & 8'h7c);
         chk8({3'h0, core_ctl.positive_channel_select}, {3'h0, rv[6:2]});
         wr_reg(acr_pkg::ADDR_RES_HI, ~rv);
         wr_reg(acr_pkg::ADDR_RES_LO, rv);
         rd_reg(acr_pkg::ADDR_RES_HI, got);
         chk8(got, ~rv);
         rd_reg(acr_pkg::ADDR_RES_LO, got);
         chk8(got, rv);
      end
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         mag_in <= 12'($random(seed));
         neg_in <= 1'($random(seed));
         rv = {i[0], 1'b0, i[2:0], 3'(7 - i)};
         wr_reg(acr_pkg::ADDR_CTL2, rv);
         wv = {1'b0, 5'($random(seed)), 2'b11};
         wr_reg(acr_pkg::ADDR_CTL0, wv);
         rd_reg(acr_pkg::ADDR_CTL0, got);
         chk8(got, wv);
         chk1(got[1], 1'b1);
         wait_done();
         rd_reg(acr_pkg::ADDR_CTL0, got);
         chk8(got & 8'h03, 8'h01);
         chk8(tick_gap, GAP_TAB[rv[2:0]]);
         chk1(acq_ticks == ACQ_TAB[rv[5:3]] ||
              (rv[5:3] == 3'h0 && acq_ticks == 8'h01), 1'b1);
         rd_reg(acr_pkg::ADDR_RES_HI, got);
         chk8(got, 8'(exp_pair(rv[7], mag_in, neg_in) >> 8));
         rd_reg(acr_pkg::ADDR_RES_LO, got);
         chk8(got, 8'(exp_pair(rv[7], mag_in, neg_in)));
      end
      $display("test conversions done");
      wr_reg(acr_pkg::ADDR_CTL0, 8'h02);
      rd_reg(acr_pkg::ADDR_CTL0, got);
      chk8(got, 8'h00);
      conv_ticks <= 8'hc8;
      wr_reg(acr_pkg::ADDR_RES_HI, 8'h5a);
      wr_reg(acr_pkg::ADDR_CTL2, 8'h06);
      wr_reg(acr_pkg::ADDR_CTL0, 8'h03);
      repeat (20) @(posedge clk);
      wr_reg(acr_pkg::ADDR_CTL0, 8'h00);
      seen = 1'b0;
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         #1;
         if (conversion_done_flag !== 1'b0) seen = 1'b1;
      end
      chk1(seen, 1'b0);
      rd_reg(acr_pkg::ADDR_CTL0, got);
      chk8(got, 8'h00);
      rd_reg(acr_pkg::ADDR_RES_HI, got);
      chk8(got, 8'h5a);
      $display("test abort done");
      conv_ticks <= 8'h04;
      wr_reg(acr_pkg::ADDR_CTL2, 8'h00);
      wr_reg(acr_pkg::ADDR_CTL0, 8'h01);
      for (int t = 0; t < 4; t++) begin
         wr_reg(acr_pkg::ADDR_CTL1, {t[1:0], 6'h00});
         pulse_trig(4'(1 << ((t + 1) % 4)));
         rd_reg(acr_pkg::ADDR_CTL0, got);
         chk8(got, 8'h01);
         pulse_trig(4'(1 << t));
         wait_done();
      end
      $display("test triggers done");
      stop_test();
   end
endmodule
